// [hw/pfpp_dev.sv]
`timescale 1ns/10ps
`include "pfpp_map.svh"
// Function
// - Action 10 plus load strobe loads command
// - Action 00 plus load strobe loads address
// - Action 01 plus load strobe loads data
// - Device latches command on strobe rising edge
// - Command 8'h80 decodes as chip erase
// - Command 8'h10 decodes as write flash
// - Write pulse after erase starts erase, busy
// - Programmer waits ready before next command
// - Byte select 00 loads address bits 7:0
// - Byte select 01 loads address bits 15:8
// - Byte select 10 loads address bits 23:16
// - Low byte select picks data half
// - Page latch stores word at low address
// - Page buffer holds data for one program
// - Low bits word, upper bits select page
// - Write pulse with select 00 programs page
// - Programmer waits ready after page program
// - Programmer repeats address, data, latch per word
// - Programmer loads high addresses, programs page
// - Command and address retained across operations
module pfpp_dev #(
  parameter int PAGE_WORDS = `PFPP_PAGE_WORDS,
  parameter int ERASE_CYC = `PFPP_ERASE_CYC,
  parameter int PROG_CYC = `PFPP_PROG_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  pfpp_if.dev link,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic mem_we,
  output logic mem_erase,
  output logic [7:0] cmd_out
);
  localparam int WB = $clog2(PAGE_WORDS);
  // Timer counts down; busy lasts the loaded count plus one cycle
  localparam int LONG = (ERASE_CYC > PROG_CYC) ? ERASE_CYC : PROG_CYC;
  localparam int CW = $clog2(LONG + 1);

  // One page of words, filled by latches and drained by a program
  logic [15:0] page_mem [PAGE_WORDS];
  logic load_d_reg, latch_d_reg, wr_d_reg;
  logic [7:0] cmd_reg, cmd_next;
  logic [23:0] addr_reg, addr_next;
  logic [7:0] dlo_reg, dlo_next, dhi_reg, dhi_next;
  pfpp_pkg::pfpp_op_t op_reg, op_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [WB-1:0] widx_reg, widx_next;
  logic [23:0] out_addr_reg, out_addr_next;
  logic [15:0] out_wdata_reg, out_wdata_next;
  logic out_we_reg, out_we_next, out_erase_reg, out_erase_next;
  logic load_rise, latch_rise, wr_fall, idle, page_wr;
  logic [1:0] act, bsel;

  // Saturating step keeps the timer from wrapping past zero
  function automatic logic [CW-1:0] count_down(input logic [CW-1:0] c);
    count_down = (c == '0) ? c : c - 1'b1;
  endfunction : count_down

  assign act = {link.action_select_hi, link.action_select_lo};
  assign bsel = {link.byte_select_hi, link.byte_select_lo};
  assign load_rise = link.load_strobe && !load_d_reg;
  assign latch_rise = link.page_latch_strobe && !latch_d_reg;
  // Write strobe is active low, so its start is a falling edge
  assign wr_fall = !link.write_n && wr_d_reg;
  assign idle = op_reg == pfpp_pkg::PFPP_OP_NONE;
  assign page_wr = latch_rise && link.byte_select_lo && idle;
  assign link.ready_busy_n = idle;
  // Outputs come from flops so the memory sees clean strobes
  assign mem_addr = out_addr_reg;
  assign mem_wdata = out_wdata_reg;
  assign mem_we = out_we_reg;
  assign mem_erase = out_erase_reg;
  assign cmd_out = cmd_reg;

  // Loads are ignored while busy, so a mid-operation address cannot move
  always_comb begin
    cmd_next = cmd_reg;
    addr_next = addr_reg;
    dlo_next = dlo_reg;
    dhi_next = dhi_reg;
    if (load_rise && op_reg == pfpp_pkg::PFPP_OP_NONE) begin
      case (act)
        `PFPP_ACT_CMD: cmd_next = link.data;
        `PFPP_ACT_ADDR: begin
          case (bsel)
            `PFPP_BS_LOW: addr_next[7:0] = link.data;
            `PFPP_BS_HIGH: addr_next[15:8] = link.data;
            `PFPP_BS_EXT: addr_next[23:16] = link.data;
            default: addr_next = addr_reg;
          endcase
        end
        `PFPP_ACT_DATA: begin
          if (link.byte_select_lo) begin
            dhi_next = link.data;
          end else begin
            dlo_next = link.data;
          end
        end
        default: cmd_next = cmd_reg;
      endcase
    end
  end

  always_comb begin
    op_next = op_reg;
    cnt_next = cnt_reg;
    widx_next = widx_reg;
    out_addr_next = out_addr_reg;
    out_wdata_next = out_wdata_reg;
    out_we_next = 1'b0;
    out_erase_next = 1'b0;
    case (op_reg)
      pfpp_pkg::PFPP_OP_NONE: begin
        // Writes with any other command, or write flash with another byte select, are dropped
        if (wr_fall && cmd_reg == `PFPP_CMD_ERASE) begin
          op_next = pfpp_pkg::PFPP_OP_ERASE;
          cnt_next = CW'(ERASE_CYC);
          out_erase_next = 1'b1;
        end else if (wr_fall && cmd_reg == `PFPP_CMD_WFLASH
                     && bsel == `PFPP_BS_LOW) begin
          op_next = pfpp_pkg::PFPP_OP_PROG;
          cnt_next = CW'(PROG_CYC);
          widx_next = '0;
        end
      end
      pfpp_pkg::PFPP_OP_PROG: begin
        // Whole page streams out in one operation
        // First word leaves on the cycle after the start
        out_we_next = (widx_reg != '0) || (cnt_reg == CW'(PROG_CYC));
        if (out_we_next) begin
          out_wdata_next = page_mem[widx_reg];
          out_addr_next = {addr_reg[23:WB], widx_reg};
          widx_next = widx_reg + 1'b1;
        end
        cnt_next = count_down(cnt_reg);
        if (cnt_reg == '0 && widx_reg == '0) begin
          op_next = pfpp_pkg::PFPP_OP_NONE;
        end
      end
      pfpp_pkg::PFPP_OP_ERASE: begin
        cnt_next = count_down(cnt_reg);
        if (cnt_reg == '0) begin
          op_next = pfpp_pkg::PFPP_OP_NONE;
        end
      end
      default: op_next = pfpp_pkg::PFPP_OP_NONE;
    endcase
  end

  // Edge samplers reset to the pins' idle levels: no false edge after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      load_d_reg <= 1'b0;
      latch_d_reg <= 1'b0;
      wr_d_reg <= 1'b1;
    end else begin
      load_d_reg <= link.load_strobe;
      latch_d_reg <= link.page_latch_strobe;
      wr_d_reg <= link.write_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_reg <= `PFPP_CMD_NOP;
      addr_reg <= '0;
      dlo_reg <= 8'hff;
      dhi_reg <= 8'hff;
    end else begin
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      dlo_reg <= dlo_next;
      dhi_reg <= dhi_next;
    end
  end

  // Timer and drain state; outputs are registered for the memory
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      op_reg <= pfpp_pkg::PFPP_OP_NONE;
      cnt_reg <= '0;
      widx_reg <= '0;
      out_addr_reg <= '0;
      out_wdata_reg <= '0;
      out_we_reg <= 1'b0;
      out_erase_reg <= 1'b0;
    end else begin
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      widx_reg <= widx_next;
      out_addr_reg <= out_addr_next;
      out_wdata_reg <= out_wdata_next;
      out_we_reg <= out_we_next;
      out_erase_reg <= out_erase_next;
    end
  end

  // No reset on the buffer; words never latched keep old data
  always_ff @(posedge ref_clk) begin
    if (page_wr) begin
      page_mem[addr_reg[WB-1:0]] <= {dhi_reg, dlo_reg};
    end
  end
endmodule : pfpp_dev

// [inc/pfpp_map.svh]
`ifndef PFPP_MAP_SVH
`define PFPP_MAP_SVH
`define PFPP_ACT_ADDR 2'h0
`define PFPP_ACT_DATA 2'h1
`define PFPP_ACT_CMD 2'h2
`define PFPP_ACT_IDLE 2'h3
`define PFPP_BS_LOW 2'h0
`define PFPP_BS_HIGH 2'h1
`define PFPP_BS_EXT 2'h2
`define PFPP_CMD_NOP 8'h00
`define PFPP_CMD_ERASE 8'h80
`define PFPP_CMD_WFLASH 8'h10
`define PFPP_ERASE_NS 10000
`define PFPP_PROG_NS 5000
`define PFPP_CLK_MHZ 200
`define PFPP_ERASE_CYC ((`PFPP_ERASE_NS * `PFPP_CLK_MHZ) / 1000)
`define PFPP_PROG_CYC ((`PFPP_PROG_NS * `PFPP_CLK_MHZ) / 1000)
`define PFPP_STROBE_CYC 2
`define PFPP_PAGE_WORDS 128
`endif

// [inc/pfpp_pkg.sv]
package pfpp_pkg;
  typedef enum logic [1:0] {
    PFPP_OP_NONE,
    PFPP_OP_ERASE,
    PFPP_OP_PROG
  } pfpp_op_t;
  typedef struct packed {
    logic [1:0] act;
    logic [1:0] bsel;
    logic [7:0] data;
    logic [1:0] kind;
  } pfpp_req_t;
endpackage : pfpp_pkg

// [inc/pfpp_if.sv]
`timescale 1ns/10ps
interface pfpp_if;
  logic action_select_hi;
  logic action_select_lo;
  logic byte_select_hi;
  logic byte_select_lo;
  logic [7:0] data;
  logic load_strobe;
  logic page_latch_strobe;
  logic write_n;
  logic ready_busy_n;
  modport dev (
    input action_select_hi, action_select_lo, byte_select_hi,
    input byte_select_lo, data, load_strobe, page_latch_strobe, write_n,
    output ready_busy_n
  );
  modport prog (
    output action_select_hi, action_select_lo, byte_select_hi,
    output byte_select_lo, data, load_strobe, page_latch_strobe, write_n,
    input ready_busy_n
  );
endinterface : pfpp_if

// [hw/pfpp_buf2.sv]
`timescale 1ns/10ps
module pfpp_buf2 #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] rd_reg, rd_next, wr_reg, wr_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready = cnt_reg != (AW + 1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    rd_next = pop ? bump(rd_reg) : rd_reg;
    wr_next = push ? bump(wr_reg) : wr_reg;
    cnt_next = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_reg <= '0;
      wr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule : pfpp_buf2

// [hw/pfpp_prog.sv]
`timescale 1ns/10ps
`include "pfpp_map.svh"
module pfpp_prog #(
  parameter int STROBE_CYC = `PFPP_STROBE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  pfpp_if.prog link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [13:0] req_data,
  output logic busy
);
  typedef enum {PFPP_S_IDLE, PFPP_S_SETUP, PFPP_S_PULSE,
    PFPP_S_HOLD, PFPP_S_WAIT} pfpp_state_t;
  pfpp_state_t st_reg, st_next;
  pfpp_pkg::pfpp_req_t cur_reg, cur_next, head;
  logic [3:0] cnt_reg, cnt_next;
  logic head_valid, head_ready, strobe;

  // Two-entry buffer: a busy device stalls the source, no word lost
  pfpp_buf2 #(.WIDTH(14), .DEPTH(2)) u_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req_data),
    .out_valid(head_valid),
    .out_ready(head_ready),
    .out_data(head)
  );

  // Kind 0 load strobe, 1 page latch, 2 write pulse
  assign head_ready = st_reg == PFPP_S_IDLE && link.ready_busy_n;
  assign strobe = st_reg == PFPP_S_PULSE;
  assign link.action_select_hi = cur_reg.act[1];
  assign link.action_select_lo = cur_reg.act[0];
  assign link.byte_select_hi = cur_reg.bsel[1];
  assign link.byte_select_lo = cur_reg.bsel[0];
  assign link.data = cur_reg.data;
  assign link.load_strobe = strobe && cur_reg.kind == 2'h0;
  assign link.page_latch_strobe = strobe && cur_reg.kind == 2'h1;
  assign link.write_n = !(strobe && cur_reg.kind == 2'h2);
  assign busy = st_reg != PFPP_S_IDLE;

  always_comb begin
    st_next = st_reg;
    cur_next = cur_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      PFPP_S_IDLE: begin
        if (head_valid && head_ready) begin
          cur_next = head;
          cnt_next = 4'(STROBE_CYC);
          st_next = PFPP_S_SETUP;
        end
      end
      PFPP_S_SETUP: begin
        cnt_next = 4'(STROBE_CYC);
        st_next = PFPP_S_PULSE;
      end
      PFPP_S_PULSE: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == 4'h1) begin
          st_next = PFPP_S_HOLD;
        end
      end
      PFPP_S_HOLD: st_next = PFPP_S_WAIT;
      PFPP_S_WAIT: begin
        if (link.ready_busy_n) begin
          st_next = PFPP_S_IDLE;
        end
      end
      default: st_next = PFPP_S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= PFPP_S_IDLE;
      cur_reg <= {`PFPP_ACT_IDLE, `PFPP_BS_LOW, 8'h00, 2'h3};
      cnt_reg <= 4'h0;
    end else begin
      st_reg <= st_next;
      cur_reg <= cur_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : pfpp_prog

// [bench/pfpp_properties.sv]
`timescale 1ns/10ps
module pfpp_properties #(
  parameter int ERASE_CYC = 20,
  parameter int PROG_CYC = 40
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic action_select_hi,
  input wire logic action_select_lo,
  input wire logic byte_select_hi,
  input wire logic byte_select_lo,
  input wire logic [7:0] data,
  input wire logic load_strobe,
  input wire logic page_latch_strobe,
  input wire logic write_n,
  input wire logic ready_busy_n
);
  logic [7:0] cmd_reg, cmd_next;
  logic ld_reg;
  int cnt_reg, cnt_next;
  logic bs0;
  assign bs0 = !byte_select_hi && !byte_select_lo;
  always_comb begin
    cmd_next = cmd_reg;
    if (load_strobe && !ld_reg && action_select_hi && !action_select_lo
        && ready_busy_n) begin
      cmd_next = data;
    end
    cnt_next = ready_busy_n ? 0 : cnt_reg + 1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_reg <= 8'h00;
      ld_reg <= 1'b0;
      cnt_reg <= 0;
    end else begin
      cmd_reg <= cmd_next;
      ld_reg <= load_strobe;
      cnt_reg <= cnt_next;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  erase_start_a: assert property ($fell(write_n) && ready_busy_n
    && cmd_reg == 8'h80 |-> ##[1:3] !ready_busy_n) else $error("no erase");
  prog_start_a: assert property ($fell(write_n) && ready_busy_n
    && cmd_reg == 8'h10 && bs0 |-> ##[1:3] !ready_busy_n)
    else $error("no page program");
  write_refused_a: assert property ($fell(write_n) && ready_busy_n
    && cmd_reg != 8'h80 && !(cmd_reg == 8'h10 && bs0)
    |-> ready_busy_n [*4]) else $error("bad write started");
  erase_len_a: assert property ($rose(ready_busy_n)
    && cmd_reg == 8'h80 |-> cnt_reg >= ERASE_CYC && cnt_reg <= ERASE_CYC + 2)
    else $error("erase length");
  prog_len_a: assert property ($rose(ready_busy_n)
    && cmd_reg == 8'h10 |-> cnt_reg >= PROG_CYC && cnt_reg <= PROG_CYC + 2)
    else $error("program length");
  busy_cause_a: assert property ($fell(ready_busy_n)
    |-> !$past(write_n) || !$past(write_n, 2) || !$past(write_n, 3))
    else $error("busy without write");
  busy_bound_a: assert property (cnt_reg <= ERASE_CYC + PROG_CYC + 2)
    else $error("busy too long");
  load_wait_a: assert property ($rose(load_strobe) |-> ready_busy_n)
    else $error("load while busy");
endmodule : pfpp_properties

// [bench/pfpp_bench.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module pfpp_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [13:0] req_data = 14'h3003;
  logic req_ready, busy, mem_we, mem_erase;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [7:0] cmd_out;
  logic [31:0] seed = 32'h2d80f0f4;
  int n_errors = 0;
  int check_count = 0;
  int n_erase = 0;
  logic [23:0] got_a[$];
  logic [15:0] got_d[$];
  always #2.5 ref_clk = ~ref_clk;
  pfpp_if link_if();
  pfpp_prog pfpp_prog_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .link(link_if), .req_valid(req_valid),
    .req_ready(req_ready), .req_data(req_data), .busy(busy));
  pfpp_dev #(.PAGE_WORDS(8), .ERASE_CYC(20), .PROG_CYC(40)) pfpp_dev_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(link_if), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_erase(mem_erase),
    .cmd_out(cmd_out));
  pfpp_properties #(.ERASE_CYC(20), .PROG_CYC(40)) pfpp_properties_inst (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .action_select_hi(link_if.action_select_hi),
    .action_select_lo(link_if.action_select_lo),
    .byte_select_hi(link_if.byte_select_hi),
    .byte_select_lo(link_if.byte_select_lo), .data(link_if.data),
    .load_strobe(link_if.load_strobe),
    .page_latch_strobe(link_if.page_latch_strobe),
    .write_n(link_if.write_n), .ready_busy_n(link_if.ready_busy_n));
  always @(posedge ref_clk) begin
    if (rst_n && mem_we === 1'b1) begin
      got_a.push_back(mem_addr);
      got_d.push_back(mem_wdata);
    end
    if (rst_n && mem_erase === 1'b1) begin
      n_erase++;
    end
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  // Valid dropped for a cycle so a held write is not resent
  task automatic send(input logic [13:0] r);
    req_data <= r;
    req_valid <= 1'b1;
    do @(negedge ref_clk); while (req_ready !== 1'b1);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    @(posedge ref_clk);
  endtask : send
  task automatic ld(input logic [1:0] a, input logic [1:0] b,
                    input logic [7:0] d);
    send({a, b, d, 2'h0});
  endtask : ld
  task automatic drain(input int n);
    int k;
    k = 0;
    while (k < 30 || ((got_a.size() < n || link_if.ready_busy_n !== 1'b1)
           && k < 3000)) begin
      @(posedge ref_clk);
      k++;
    end
  endtask : drain
  task automatic page();
    logic [7:0] ext, hi, pg, dl, dh;
    logic [23:0] ea[$];
    logic [15:0] ed[$];
    ext = rnd();
    hi = rnd();
    pg = rnd();
    for (int i = 0; i < 8; i++) begin
      dl = rnd();
      dh = rnd();
      ld(2'h0, 2'h0, {pg[4:0], 3'(i)});
      ld(2'h1, 2'h0, dl);
      ld(2'h1, 2'h1, dh);
      send(14'h3401);
      ea.push_back({ext, hi, pg[4:0], 3'(i)});
      ed.push_back({dh, dl});
    end
    ld(2'h0, 2'h1, hi);
    ld(2'h0, 2'h2, ext);
    send(14'h3002);
    drain(8);
    for (int i = 0; i < 8; i++) begin
      `CHK("mem_addr", ea[i], got_a[i])
      `CHK("mem_wdata", ed[i], got_d[i])
    end
    got_a.delete();
    got_d.delete();
  endtask : page
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    ld(2'h2, 2'h0, 8'h80);
    send(14'h3002);
    drain(0);
    `CHK("erase", 1, n_erase)
    `CHK("busy", 1'b0, busy)
    `CHK("ready", 1'b1, link_if.ready_busy_n)
    `CHK("cmd_out", 8'h80, cmd_out)
    ld(2'h2, 2'h0, 8'h10);
    page();
    send(14'h3402);
    drain(0);
    `CHK("bad write", 0, got_a.size())
    page();
    `CHK("cmd_out", 8'h10, cmd_out)
    ld(2'h2, 2'h0, 8'h00);
    send(14'h3002);
    drain(0);
    `CHK("nop write", 0, got_a.size())
    `CHK("nop erase", 1, n_erase)
    complete_run();
  end
endmodule : pfpp_bench
